// ==== src/atc_pkg.sv ====
package atc_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int ATC_ADDR_W = 9;
  localparam int ATC_DATA_W = 32;
  localparam int ATC_BE_W = 4;
  localparam int ATC_REG_W = 8;
  localparam int ATC_IDX_W = 7;
  localparam logic [1:0] ATC_WORD_ALIGN = 2'h0;

  // ---------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [ATC_IDX_W-1:0] ATC_IDX_DETECT_CTRL = 7'h57;
  localparam logic [ATC_IDX_W-1:0] ATC_IDX_ATTACK_TIME = 7'h59;
  localparam logic [ATC_IDX_W-1:0] ATC_IDX_DECAY_TIME = 7'h5A;
  localparam logic [ATC_IDX_W-1:0] ATC_IDX_NOISE_DEBOUNCE = 7'h5B;
  localparam logic [ATC_IDX_W-1:0] ATC_IDX_SIGNAL_DEBOUNCE = 7'h5C;
  localparam logic [ATC_IDX_W-1:0] ATC_IDX_STATUS = 7'h70;

  localparam logic [ATC_REG_W-1:0] ATC_RST_TIME = 8'h00;
  localparam logic [ATC_REG_W-1:0] ATC_RST_DEBOUNCE = 8'h00;
  localparam logic [ATC_REG_W-1:0] ATC_RST_DETECT_CTRL = 8'h00;

  // ---------------------------------------------------------------
  // Field layouts
  // ---------------------------------------------------------------
  localparam int ATC_TIME_CODE_MSB = 7;
  localparam int ATC_TIME_CODE_LSB = 3;
  localparam int ATC_TIME_MULT_MSB = 2;
  localparam int ATC_TIME_MULT_LSB = 0;
  localparam int ATC_NOISE_CODE_MSB = 4;
  localparam int ATC_SIGNAL_CODE_MSB = 3;
  localparam int ATC_THRESH_MSB = 5;
  localparam int ATC_THRESH_LSB = 1;
  localparam int ATC_STAT_NOISE_QUIET = 0;
  localparam int ATC_STAT_SIGNAL_HOLD = 1;
  localparam int ATC_STAT_DETECT_EN = 2;

  // ---------------------------------------------------------------
  // Timing scales, in ADC sample periods
  // ---------------------------------------------------------------
  localparam int ATC_PERIOD_W = 22;
  localparam int ATC_DEB_W = 17;
  localparam int ATC_ATTACK_BASE_SHIFT = 5;
  localparam int ATC_DECAY_BASE_SHIFT = 9;
  localparam int ATC_NOISE_POW_LAST = 11;
  localparam int ATC_NOISE_MULT_OFS = 9;
  localparam int ATC_NOISE_MULT_MAX = 20;
  localparam int ATC_NOISE_UNIT_SHIFT = 12;
  localparam int ATC_SIGNAL_POW_LAST = 10;
  localparam int ATC_SIGNAL_MULT_OFS = 8;
  localparam int ATC_SIGNAL_MULT_MAX = 5;
  localparam int ATC_SIGNAL_UNIT_SHIFT = 11;
  localparam logic [ATC_DEB_W-1:0] ATC_POW_SEED = 17'h00002;

endpackage

// ==== src/atc_sample_timer.sv ====
`timescale 1ns/100ps
module atc_sample_timer #(
  parameter int W = 22,
  parameter bit PERIODIC = 1'b0
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic [W-1:0] limit_i,
  output logic hit_o
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic hit_reg;
  logic hit_next;
  logic [W-1:0] count_inc;

  assign count_inc = W'(count_reg + W'(1));
  assign hit_o = hit_reg;

  // ---------------------------------------------------------------
  // Sample counter
  // ---------------------------------------------------------------
  always_comb begin
    count_next = count_reg;
    hit_next = hit_reg;
    if (!run_i) begin
      // Broken condition restarts the count
      count_next = '0;
      hit_next = 1'b0;
    end else if (PERIODIC) begin
      hit_next = 1'b0;
      if (tick_i) begin
        if (count_inc >= limit_i) begin
          count_next = '0;
          hit_next = 1'b1;
        end else begin
          count_next = count_inc;
        end
      end
    end else begin
      // Level stays up while the condition keeps holding
      if (count_reg >= limit_i) begin
        hit_next = 1'b1;
      end else if (tick_i) begin
        count_next = count_inc;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      count_reg <= '0;
      hit_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      hit_reg <= hit_next;
    end
  end

endmodule

// ==== src/atc_timing_config.sv ====
// Contract
// - Attack bits 7..3 hold code n giving a base attack time of (2n+1)*32 sample periods.
// - Attack bits 2..0 hold m, and the base attack time is multiplied by 2 to the m.
// - Decay bits 7..3 hold code n giving a base decay time of (2n+1)*512 sample periods.
// - Decay bits 2..0 hold m, and the base decay time is multiplied by 2 to the m.
// - Noise debounce bits 4..0 select 0,4,8,16,32, then powers of two to 4096, then multiples of 4096 up to 20.
// - Signal debounce bits 3..0 select 0,4,8,16,32, then powers of two to 2048, then 3, 4 and 5 times 2048.
// - A zero noise threshold disables noise detection, so the noise debounce has no effect.
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/100ps
module atc_timing_config (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [atc_pkg::ATC_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [atc_pkg::ATC_DATA_W-1:0] avs_writedata_i,
  input wire logic [atc_pkg::ATC_BE_W-1:0] avs_byteenable_i,
  output logic [atc_pkg::ATC_DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic sample_tick_i,
  input wire logic below_noise_i,
  input wire logic signal_present_i,
  output logic attack_tick_o,
  output logic decay_tick_o,
  output logic noise_quiet_o,
  output logic signal_hold_o,
  output logic noise_detect_en_o,
  output logic [atc_pkg::ATC_PERIOD_W-1:0] attack_len_o,
  output logic [atc_pkg::ATC_PERIOD_W-1:0] decay_len_o
);
  import atc_pkg::*;

  // ---------------------------------------------------------------
  // Decoders
  // ---------------------------------------------------------------
  function automatic logic [ATC_PERIOD_W-1:0] time_len(input logic [ATC_REG_W-1:0] r, input int base_shift);
    logic [ATC_PERIOD_W-1:0] odd;
    odd = ATC_PERIOD_W'({r[ATC_TIME_CODE_MSB:ATC_TIME_CODE_LSB], 1'b1});
    // (2n+1) * base, then the power-of-two multiplier
    return (odd << base_shift) << r[ATC_TIME_MULT_MSB:ATC_TIME_MULT_LSB];
  endfunction

  function automatic logic [ATC_DEB_W-1:0] deb_len(input logic [4:0] c, input int pow_last,
                                                     input int mult_ofs, input int mult_max, input int unit_shift);
    int mult;
    mult = 0;
    if (c == 5'h00) begin
      return '0;
    end else if (int'(c) <= pow_last) begin
      return ATC_POW_SEED << c;
    end else begin
      mult = int'(c) - mult_ofs;
      if (mult > mult_max) begin
        mult = mult_max;
      end
      return ATC_DEB_W'(mult << unit_shift);
    end
  endfunction

  // ---------------------------------------------------------------
  // Register file state
  // ---------------------------------------------------------------
  logic [ATC_REG_W-1:0] attack_time_reg;
  logic [ATC_REG_W-1:0] attack_time_next;
  logic [ATC_REG_W-1:0] decay_time_reg;
  logic [ATC_REG_W-1:0] decay_time_next;
  logic [ATC_REG_W-1:0] noise_deb_reg;
  logic [ATC_REG_W-1:0] noise_deb_next;
  logic [ATC_REG_W-1:0] signal_deb_reg;
  logic [ATC_REG_W-1:0] signal_deb_next;
  logic [ATC_REG_W-1:0] detect_ctrl_reg;
  logic [ATC_REG_W-1:0] detect_ctrl_next;
  logic waitrequest_reg;
  logic waitrequest_next;
  logic [ATC_DATA_W-1:0] readdata_reg;
  logic [ATC_DATA_W-1:0] readdata_next;

  logic [ATC_IDX_W-1:0] idx;
  logic aligned;
  logic wr_fire;
  logic [ATC_REG_W-1:0] status_byte;

  assign idx = avs_address_i[ATC_ADDR_W-1:2];
  assign aligned = (avs_address_i[1:0] == ATC_WORD_ALIGN);
  // Write lands on the edge where the master sees waitrequest low
  assign wr_fire = avs_write_i && !waitrequest_reg && aligned && avs_byteenable_i[0];

  // ---------------------------------------------------------------
  // Avalon slave, one wait state per access
  // ---------------------------------------------------------------
  always_comb begin
    waitrequest_next = 1'b1;
    readdata_next = readdata_reg;
    if ((avs_read_i || avs_write_i) && waitrequest_reg) begin
      waitrequest_next = 1'b0;
      readdata_next = '0;
      if (avs_read_i && aligned) begin
        unique case (idx)
          ATC_IDX_ATTACK_TIME: readdata_next = ATC_DATA_W'(attack_time_reg);
          ATC_IDX_DECAY_TIME: readdata_next = ATC_DATA_W'(decay_time_reg);
          ATC_IDX_NOISE_DEBOUNCE: readdata_next = ATC_DATA_W'(noise_deb_reg);
          ATC_IDX_SIGNAL_DEBOUNCE: readdata_next = ATC_DATA_W'(signal_deb_reg);
          ATC_IDX_DETECT_CTRL: readdata_next = ATC_DATA_W'(detect_ctrl_reg);
          ATC_IDX_STATUS: readdata_next = ATC_DATA_W'(status_byte);
          default: readdata_next = '0;
        endcase
      end
    end
  end

  always_comb begin
    attack_time_next = attack_time_reg;
    decay_time_next = decay_time_reg;
    noise_deb_next = noise_deb_reg;
    signal_deb_next = signal_deb_reg;
    detect_ctrl_next = detect_ctrl_reg;
    if (wr_fire) begin
      unique case (idx)
        ATC_IDX_ATTACK_TIME: attack_time_next = avs_writedata_i[ATC_REG_W-1:0];
        ATC_IDX_DECAY_TIME: decay_time_next = avs_writedata_i[ATC_REG_W-1:0];
        ATC_IDX_NOISE_DEBOUNCE: noise_deb_next = avs_writedata_i[ATC_REG_W-1:0];
        ATC_IDX_SIGNAL_DEBOUNCE: signal_deb_next = avs_writedata_i[ATC_REG_W-1:0];
        ATC_IDX_DETECT_CTRL: detect_ctrl_next = avs_writedata_i[ATC_REG_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      attack_time_reg <= ATC_RST_TIME;
      decay_time_reg <= ATC_RST_TIME;
      noise_deb_reg <= ATC_RST_DEBOUNCE;
      signal_deb_reg <= ATC_RST_DEBOUNCE;
      detect_ctrl_reg <= ATC_RST_DETECT_CTRL;
      waitrequest_reg <= 1'b1;
      readdata_reg <= '0;
    end else begin
      attack_time_reg <= attack_time_next;
      decay_time_reg <= decay_time_next;
      noise_deb_reg <= noise_deb_next;
      signal_deb_reg <= signal_deb_next;
      detect_ctrl_reg <= detect_ctrl_next;
      waitrequest_reg <= waitrequest_next;
      readdata_reg <= readdata_next;
    end
  end

  assign avs_waitrequest_o = waitrequest_reg;
  assign avs_readdata_o = readdata_reg;

  // ---------------------------------------------------------------
  // Decoded durations, registered to keep the decode off the counters
  // ---------------------------------------------------------------
  logic [ATC_PERIOD_W-1:0] attack_len_reg;
  logic [ATC_PERIOD_W-1:0] attack_len_next;
  logic [ATC_PERIOD_W-1:0] decay_len_reg;
  logic [ATC_PERIOD_W-1:0] decay_len_next;
  logic [ATC_DEB_W-1:0] noise_len_reg;
  logic [ATC_DEB_W-1:0] noise_len_next;
  logic [ATC_DEB_W-1:0] signal_len_reg;
  logic [ATC_DEB_W-1:0] signal_len_next;
  logic detect_en_reg;
  logic detect_en_next;

  always_comb begin
    attack_len_next = time_len(attack_time_reg, ATC_ATTACK_BASE_SHIFT);
    decay_len_next = time_len(decay_time_reg, ATC_DECAY_BASE_SHIFT);
    // Upper reserved bits are stored but never decoded
    noise_len_next = deb_len(noise_deb_reg[ATC_NOISE_CODE_MSB:0], ATC_NOISE_POW_LAST, ATC_NOISE_MULT_OFS,
                             ATC_NOISE_MULT_MAX, ATC_NOISE_UNIT_SHIFT);
    signal_len_next = deb_len({1'b0, signal_deb_reg[ATC_SIGNAL_CODE_MSB:0]}, ATC_SIGNAL_POW_LAST,
                              ATC_SIGNAL_MULT_OFS, ATC_SIGNAL_MULT_MAX, ATC_SIGNAL_UNIT_SHIFT);
    detect_en_next = (detect_ctrl_reg[ATC_THRESH_MSB:ATC_THRESH_LSB] != '0);
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      attack_len_reg <= '0;
      decay_len_reg <= '0;
      noise_len_reg <= '0;
      signal_len_reg <= '0;
      detect_en_reg <= 1'b0;
    end else begin
      attack_len_reg <= attack_len_next;
      decay_len_reg <= decay_len_next;
      noise_len_reg <= noise_len_next;
      signal_len_reg <= signal_len_next;
      detect_en_reg <= detect_en_next;
    end
  end

  assign attack_len_o = attack_len_reg;
  assign decay_len_o = decay_len_reg;
  assign noise_detect_en_o = detect_en_reg;

  // ---------------------------------------------------------------
  // Timers
  // ---------------------------------------------------------------
  logic timers_live;
  logic noise_run;
  logic noise_hit;
  logic signal_hit;

  // Attack and decay timers wait one cycle after reset so the decoded lengths are valid
  assign timers_live = (attack_len_reg != '0);
  // Noise detection off means the noise debounce never fires
  assign noise_run = below_noise_i && detect_en_reg;

  atc_sample_timer #(
    .W(ATC_PERIOD_W),
    .PERIODIC(1'b1)
  ) u_attack (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .run_i(timers_live),
    .tick_i(sample_tick_i),
    .limit_i(attack_len_reg),
    .hit_o(attack_tick_o)
  );

  atc_sample_timer #(
    .W(ATC_PERIOD_W),
    .PERIODIC(1'b1)
  ) u_decay (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .run_i(timers_live),
    .tick_i(sample_tick_i),
    .limit_i(decay_len_reg),
    .hit_o(decay_tick_o)
  );

  atc_sample_timer #(
    .W(ATC_DEB_W),
    .PERIODIC(1'b0)
  ) u_noise (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .run_i(noise_run),
    .tick_i(sample_tick_i),
    .limit_i(noise_len_reg),
    .hit_o(noise_hit)
  );

  atc_sample_timer #(
    .W(ATC_DEB_W),
    .PERIODIC(1'b0)
  ) u_signal (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .run_i(signal_present_i),
    .tick_i(sample_tick_i),
    .limit_i(signal_len_reg),
    .hit_o(signal_hit)
  );

  assign noise_quiet_o = noise_hit;
  assign signal_hold_o = signal_hit;

  // ---------------------------------------------------------------
  // Status readback
  // ---------------------------------------------------------------
  always_comb begin
    status_byte = '0;
    status_byte[ATC_STAT_NOISE_QUIET] = noise_hit;
    status_byte[ATC_STAT_SIGNAL_HOLD] = signal_hit;
    status_byte[ATC_STAT_DETECT_EN] = detect_en_reg;
  end

endmodule

// ==== testbench/atc_timing_config_props.sv ====
`timescale 1ns/100ps
module atc_timing_config_props (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [atc_pkg::ATC_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [atc_pkg::ATC_DATA_W-1:0] avs_writedata_i,
  input wire logic [atc_pkg::ATC_BE_W-1:0] avs_byteenable_i,
  input wire logic [atc_pkg::ATC_DATA_W-1:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic sample_tick_i,
  input wire logic below_noise_i,
  input wire logic signal_present_i,
  input wire logic attack_tick_o,
  input wire logic decay_tick_o,
  input wire logic noise_quiet_o,
  input wire logic signal_hold_o,
  input wire logic noise_detect_en_o,
  input wire logic [atc_pkg::ATC_PERIOD_W-1:0] attack_len_o,
  input wire logic [atc_pkg::ATC_PERIOD_W-1:0] decay_len_o
);
  import atc_pkg::*;
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [ATC_PERIOD_W-1:0] span(input logic [7:0] v, input int sh);
    return ATC_PERIOD_W'((2 * int'(v[7:3]) + 1) << (sh + int'(v[2:0])));
  endfunction
  sequence wr_hit(idx);
    avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && avs_address_i == {idx, ATC_WORD_ALIGN};
  endsequence
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  attack_len_a: assert property (wr_hit(ATC_IDX_ATTACK_TIME) |-> ##2
    attack_len_o == span($past(avs_writedata_i[7:0], 2), 5)) else $error("attack length wrong");
  decay_len_a: assert property (wr_hit(ATC_IDX_DECAY_TIME) |-> ##2
    decay_len_o == span($past(avs_writedata_i[7:0], 2), 9)) else $error("decay length wrong");
  attack_gap_a: assert property (attack_tick_o |=> (!attack_tick_o) [*8])
    else $error("attack ticks too close");
  decay_gap_a: assert property (decay_tick_o |=> (!decay_tick_o) [*8])
    else $error("decay ticks too close");
  quiet_off_a: assert property ((!noise_detect_en_o ##1 !noise_detect_en_o) |-> !noise_quiet_o)
    else $error("noise quiet while detection off");
  quiet_drop_a: assert property (noise_quiet_o && !below_noise_i |=> !noise_quiet_o)
    else $error("noise quiet outlived its condition");
  hold_drop_a: assert property (signal_hold_o && !signal_present_i |=> !signal_hold_o)
    else $error("signal hold outlived its condition");
  hold_cause_a: assert property ($rose(signal_hold_o) |-> $past(signal_present_i))
    else $error("signal hold rose without signal");
  answer_bound_a: assert property ((avs_read_i || avs_write_i) |-> ##[0:2] !avs_waitrequest_o)
    else $error("bus request not answered");
  read_upper_a: assert property (avs_readdata_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  cover property (attack_tick_o);
  cover property (decay_tick_o);
  cover property ($rose(noise_quiet_o));
  cover property ($rose(signal_hold_o));
endmodule

bind atc_timing_config atc_timing_config_props u_atc_timing_config_props (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .sample_tick_i(sample_tick_i),
  .below_noise_i(below_noise_i), .signal_present_i(signal_present_i), .attack_tick_o(attack_tick_o),
  .decay_tick_o(decay_tick_o), .noise_quiet_o(noise_quiet_o), .signal_hold_o(signal_hold_o),
  .noise_detect_en_o(noise_detect_en_o), .attack_len_o(attack_len_o), .decay_len_o(decay_len_o));

// ==== testbench/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  import atc_pkg::*;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [ATC_ADDR_W-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [ATC_DATA_W-1:0] avs_writedata_i = '0;
  logic [ATC_BE_W-1:0] avs_byteenable_i = '0;
  logic sample_tick_i = 1'b0;
  logic below_noise_i = 1'b0;
  logic signal_present_i = 1'b0;
  logic half_rate = 1'b0;
  logic [ATC_DATA_W-1:0] avs_readdata_o;
  logic avs_waitrequest_o, attack_tick_o, decay_tick_o, noise_quiet_o, signal_hold_o, noise_detect_en_o;
  logic [ATC_PERIOD_W-1:0] attack_len_o, decay_len_o;
  int fails = 0;
  int total_checks = 0;

  always #12.5 clock_i = ~clock_i;
  // Half rate gives a sample every other clock, so counts must skip idle cycles
  always @(posedge clock_i) begin
    sample_tick_i <= half_rate ? ~sample_tick_i : 1'b1;
  end

  atc_timing_config u_atc_timing_config (.clock_i(clock_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .sample_tick_i(sample_tick_i), .below_noise_i(below_noise_i), .signal_present_i(signal_present_i),
    .attack_tick_o(attack_tick_o), .decay_tick_o(decay_tick_o), .noise_quiet_o(noise_quiet_o),
    .signal_hold_o(signal_hold_o), .noise_detect_en_o(noise_detect_en_o), .attack_len_o(attack_len_o),
    .decay_len_o(decay_len_o));

  // ---------------------------------------------------------------
  // Expected lengths and shared tasks
  // ---------------------------------------------------------------
  function automatic int time_len(input logic [7:0] v, input int sh);
    return (2 * int'(v[7:3]) + 1) << (sh + int'(v[2:0]));
  endfunction
  function automatic int noise_len(input int c);
    if (c == 0) return 0;
    if (c <= 11) return 2 << c;
    return (c - 9 > 20 ? 20 : c - 9) * 4096;
  endfunction
  function automatic int signal_len(input int c);
    if (c == 0) return 0;
    if (c <= 10) return 2 << c;
    return (c - 8 > 5 ? 5 : c - 8) * 2048;
  endfunction

  task automatic complete_run();
    $display("Checks made: %0d, mismatches: %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
      fails++;
    end
  endtask

  task automatic bus(input logic rd, input logic [6:0] idx, input logic [7:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock_i);
    avs_read_i <= rd;
    avs_write_i <= ~rd;
    avs_address_i <= {idx, ATC_WORD_ALIGN};
    avs_writedata_i <= {24'h000000, d};
    avs_byteenable_i <= be;
    // Only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    chk("bus latency", 32'h2, 32'(n));
  endtask

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b0, idx, d, 4'h1, q);
  endtask

  task automatic rd_chk(input string name, input logic [6:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b1, idx, 8'h00, 4'hF, q);
    chk(name, {24'h000000, exp}, q);
  endtask

  // Clocks from the condition edge until the level is seen high
  task automatic meas(input bit sig, output int n);
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while ((sig ? signal_hold_o : noise_quiet_o) !== 1'b1 && n < 20000);
  endtask

  task automatic gap(input bit dec, output int n);
    for (int i = 0; i < 3000 && (dec ? decay_tick_o : attack_tick_o) !== 1'b1; i++) @(posedge clock_i);
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while ((dec ? decay_tick_o : attack_tick_o) !== 1'b1 && n < 3000);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 4; i++) rd_chk("reset value", ATC_IDX_ATTACK_TIME + 7'(i), 8'h00);
    chk("attack length", 32'h20, 32'(attack_len_o));
    chk("decay length", 32'h200, 32'(decay_len_o));
    chk("detect enable", 32'h0, 32'(noise_detect_en_o));
  endtask

  task automatic t_regs();
    logic [7:0] vals [4] = '{8'h00, 8'hFF, 8'hA5, 8'h3A};
    logic [31:0] q;
    for (int i = 0; i < 4; i++) begin
      wr(ATC_IDX_ATTACK_TIME, vals[i]);
      wr(ATC_IDX_DECAY_TIME, ~vals[i]);
      rd_chk("attack reg", ATC_IDX_ATTACK_TIME, vals[i]);
      rd_chk("decay reg", ATC_IDX_DECAY_TIME, ~vals[i]);
      chk("attack length", time_len(vals[i], 5), 32'(attack_len_o));
      chk("decay length", time_len(~vals[i], 9), 32'(decay_len_o));
    end
    bus(1'b0, ATC_IDX_ATTACK_TIME, 8'h55, 4'h0, q);
    rd_chk("masked write", ATC_IDX_ATTACK_TIME, 8'h3A);
    wr(7'h10, 8'h77);
    rd_chk("unmapped read", 7'h10, 8'h00);
  endtask

  task automatic t_noise_off();
    wr(ATC_IDX_DETECT_CTRL, 8'h00);
    below_noise_i <= 1'b1;
    repeat (10) @(posedge clock_i);
    chk("quiet while disabled", 32'h0, 32'(noise_quiet_o));
    wr(ATC_IDX_DETECT_CTRL, 8'h3E);
    repeat (4) @(posedge clock_i);
    chk("detect enable", 32'h1, 32'(noise_detect_en_o));
    chk("quiet when enabled", 32'h1, 32'(noise_quiet_o));
    rd_chk("detect ctrl reg", ATC_IDX_DETECT_CTRL, 8'h3E);
    rd_chk("status reg", ATC_IDX_STATUS, 8'h05);
    wr(ATC_IDX_DETECT_CTRL, 8'h00);
    repeat (3) @(posedge clock_i);
    chk("quiet after disable", 32'h0, 32'(noise_quiet_o));
    chk("detect disabled", 32'h0, 32'(noise_detect_en_o));
    wr(ATC_IDX_DETECT_CTRL, 8'h3E);
    below_noise_i <= 1'b0;
  endtask

  task automatic t_period();
    int n;
    half_rate <= 1'b1;
    wr(ATC_IDX_ATTACK_TIME, 8'h09);
    wr(ATC_IDX_DECAY_TIME, 8'h00);
    gap(1'b0, n);
    chk("attack period", 2 * time_len(8'h09, 5), 32'(n));
    gap(1'b1, n);
    chk("decay period", 2 * time_len(8'h00, 9), 32'(n));
    half_rate <= 1'b0;
  endtask

  task automatic t_restart();
    int n;
    wr(ATC_IDX_SIGNAL_DEBOUNCE, 8'h02);
    signal_present_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    signal_present_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    signal_present_i <= 1'b0;
    @(posedge clock_i);
    signal_present_i <= 1'b1;
    meas(1'b1, n);
    chk("restart", 32'(signal_len(2) + 2), 32'(n));
  endtask

  // Noise codes above 12 are skipped, their counts would overrun the run budget
  task automatic t_deb(input int c);
    int nn;
    int ns;
    wr(ATC_IDX_NOISE_DEBOUNCE, 8'(c));
    wr(ATC_IDX_SIGNAL_DEBOUNCE, 8'(c));
    below_noise_i <= 1'b0;
    signal_present_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    below_noise_i <= (c <= 12);
    signal_present_i <= 1'b1;
    fork
      meas(1'b1, ns);
      if (c <= 12) meas(1'b0, nn);
    join
    chk("signal debounce", 32'(signal_len(c) + 2), 32'(ns));
    if (c <= 12) chk("noise debounce", 32'(noise_len(c) + 2), 32'(nn));
  endtask

  initial begin
    repeat (16) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    t_reset();
    t_regs();
    t_noise_off();
    t_period();
    t_restart();
    for (int c = 0; c < 16; c++) t_deb(c);
    complete_run();
  end

  initial begin
    repeat (80000) @(posedge clock_i);
    fails++;
    complete_run();
  end
endmodule
